// >>> src/bkc_consts.vh
/*
 Constants for the breakpoint compare and masking block: register
 offsets, field positions and reset values.
 Assumes inclusion by bare name from the design files under src/.
*/
`ifndef BKC_CONSTS_VH
`define BKC_CONSTS_VH

// Register offsets (byte addresses on the plain register port)
`define BKC_OFF_CTRL 8'h20
`define BKC_OFF_MASKDIR 8'h29
`define BKC_OFF_CAX 8'h2a
`define BKC_OFF_CAH 8'h2b
`define BKC_OFF_CAL 8'h2c
`define BKC_OFF_CBX 8'h2d
`define BKC_OFF_CBH 8'h2e
`define BKC_OFF_CBL 8'h2f
`define BKC_OFF_STAT 8'h30

// Mask/direction control fields
`define BKC_AMASK_HI 7
`define BKC_AMASK_LO 6
`define BKC_BMASK_HI 5
`define BKC_BMASK_LO 4
`define BKC_COMP_A_DIR_CHECK_ENABLE 3
`define BKC_RWA 2
`define BKC_COMP_B_DIR_CHECK_ENABLE 1
`define BKC_RWB 0

// Own control register fields
`define BKC_CTRL_LEGACY 0
`define BKC_CTRL_TRACE 1
`define BKC_CTRL_FULL 2

// Extension register fields
`define BKC_PSEL_LO 6
`define BKC_EXT_MSB 5

// Reset values
`define BKC_RST_BYTE 8'h00
`define BKC_RST_CTRL 3'h0

// Status fields
`define BKC_STAT_LEGACY 0
`define BKC_STAT_TRACE 1
`define BKC_STAT_MA 2
`define BKC_STAT_MB 3

`endif

// >>> src/bkc_addr_cmp.v
/*
 One address comparator with byte masking and page extension compare.
 Assumes the core's address, page and flash-access signals are
 synchronous with the bus clock; purely combinational.
*/
`timescale 1ns/1ps
`include "bkc_consts.vh"

module bkc_addr_cmp (
  input wire [7:0] i_ext,
  input wire [7:0] i_high,
  input wire [7:0] i_low,
  input wire i_mask_hi,
  input wire i_mask_lo,
  input wire i_legacy,
  input wire i_trace,
  input wire i_page_sel,
  input wire [15:0] i_addr,
  input wire [21:14] i_xaddr,
  input wire i_flash_access,
  output wire o_match
);
  wire [5:0] ext_bits = i_ext[`BKC_EXT_MSB:0];
  // Bit 7 of the selector is ignored, so 10 acts as 00, 11 as 01
  wire psel_paged = i_ext[`BKC_PSEL_LO];
  // Legacy ignores the selector and pages only on flash/ROM
  wire paged = i_legacy ? i_flash_access :
    (i_trace & psel_paged & i_page_sel);
  wire [5:0] ext_target = i_legacy ? i_xaddr[19:14] : i_xaddr[21:16];
  // Extension compare only with a page selected
  wire ext_ok = ~paged | (ext_bits == ext_target);
  // Legacy paged: six high bits against address 13:8
  // Trace paged: extended 15:14 replace address 15:14
  // Unpaged: the full 16-bit CPU address
  wire [7:0] hi_target = (paged & ~i_legacy) ?
    {i_xaddr[15:14], i_addr[13:8]} : i_addr[15:8];
  wire hi_eq = (paged & i_legacy) ?
    (i_high[5:0] == i_addr[13:8]) : (i_high == hi_target);
  wire lo_eq = (i_low == i_addr[7:0]);
  // 1:0 ignores the high mask bit; 1:1 leaves only the page
  wire skip_lo = i_mask_lo;
  wire skip_hi = i_mask_hi & i_mask_lo;
  // Masked bytes count as matching
  assign o_match = ext_ok & (skip_hi | hi_eq) & (skip_lo | lo_eq);
endmodule

// >>> src/bkc_data_cmp.v
/*
 Data comparator used by comparator B in full mode.
 Assumes the data bus is valid in the same cycle as the address.
*/
`timescale 1ns/1ps
`include "bkc_consts.vh"

module bkc_data_cmp (
  input wire [7:0] i_high,
  input wire [7:0] i_low,
  input wire i_mask_hi,
  input wire i_mask_lo,
  input wire [15:0] i_data,
  output wire o_match
);
  // 0:1 high only, 1:0 low only, 1:1 none; masked bytes match
  // The high mask bit drops the high byte, the low mask bit the low byte
  assign o_match = (i_mask_hi | (i_high == i_data[15:8])) &
    (i_mask_lo | (i_low == i_data[7:0]));
endmodule

// >>> src/bkc_breakpoint_compare.v
/*
 Breakpoint compare and masking for comparators A and B, with a plain
 register port, registered match outputs and a status register.
 Assumes the core's bus signals are synchronous to i_clk and valid for
 one cycle per bus access, qualified by i_bus_valid.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "bkc_consts.vh"

// What this block does
// - Second mask x:0 full, 0:1 skip low byte, 1:1 extension only
// - Paged full compare uses extension, low byte, and high 5:0 in legacy or high 7:0 in trace
// - Unpaged full compare matches the 16-bit CPU address
// - Mask 1:0 behaves as full compare, high mask ignored
// - Mask 1:1 matches any access to the chosen page
// - Full mode B data mask: both, high, low, or none; no extension
// - First mask uses the same encoding for comparator A
// - Control bit 3 enables direction check for A
// - Control bit 2 picks A direction: 0 write, 1 read
// - Control bit 1 enables direction check for B
// - Control bit 0 picks B direction; ignored in full mode
// - Page type selector bit 7 ignored in trace mode
// - Legacy mode: flash accesses compare extension to 19:14
// - Trace selector 00 unpaged, 01 extension to 21:16
// - Extension bits compared with the core page signal
// - Program page treated as six bits
// - Legacy overrides trace; trace blocked when secured
// - Full mode: A address, B data; dual: two addresses
module bkc_breakpoint_compare (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire i_secure,
  input wire i_bus_valid,
  input wire [15:0] i_cpu_addr,
  input wire [21:14] i_ext_addr,
  input wire [15:0] i_cpu_data,
  input wire i_cpu_read,
  input wire i_page_sel,
  input wire i_flash_access,
  output reg [7:0] o_reg_rdata,
  output reg o_match_a,
  output reg o_match_b
);
  reg [7:0] maskdir_q;
  reg [7:0] cax_q;
  reg [7:0] cah_q;
  reg [7:0] cal_q;
  reg [7:0] cbx_q;
  reg [7:0] cbh_q;
  reg [7:0] cbl_q;
  reg [2:0] ctrl_q;
  reg [7:0] rdata_d;

  // Legacy wins over trace; trace refused while secured
  wire legacy = ctrl_q[`BKC_CTRL_LEGACY];
  wire trace = ctrl_q[`BKC_CTRL_TRACE] & ~legacy & ~i_secure;
  wire full = ctrl_q[`BKC_CTRL_FULL];

  // Direction qualifier: disabled check always matches
  function dir_ok;
    input en;
    input val;
    input rd;
    begin
      dir_ok = ~en | (val == rd);
    end
  endfunction

  wire addr_a_ok;
  wire addr_b_ok;
  wire data_b_ok;

  // Comparator A: first address, its own mask pair
  bkc_addr_cmp u_cmp_a (
    .i_ext(cax_q),
    .i_high(cah_q),
    .i_low(cal_q),
    .i_mask_hi(maskdir_q[`BKC_AMASK_HI]),
    .i_mask_lo(maskdir_q[`BKC_AMASK_LO]),
    .i_legacy(legacy),
    .i_trace(trace),
    .i_page_sel(i_page_sel),
    .i_addr(i_cpu_addr),
    .i_xaddr(i_ext_addr),
    .i_flash_access(i_flash_access),
    .o_match(addr_a_ok)
  );

  // Comparator B in dual mode: second address
  bkc_addr_cmp u_cmp_b (
    .i_ext(cbx_q),
    .i_high(cbh_q),
    .i_low(cbl_q),
    .i_mask_hi(maskdir_q[`BKC_BMASK_HI]),
    .i_mask_lo(maskdir_q[`BKC_BMASK_LO]),
    .i_legacy(legacy),
    .i_trace(trace),
    .i_page_sel(i_page_sel),
    .i_addr(i_cpu_addr),
    .i_xaddr(i_ext_addr),
    .i_flash_access(i_flash_access),
    .o_match(addr_b_ok)
  );

  // Comparator B in full mode: data, extension unused
  bkc_data_cmp u_cmp_d (
    .i_high(cbh_q),
    .i_low(cbl_q),
    .i_mask_hi(maskdir_q[`BKC_BMASK_HI]),
    .i_mask_lo(maskdir_q[`BKC_BMASK_LO]),
    .i_data(i_cpu_data),
    .o_match(data_b_ok)
  );

  wire dir_a = dir_ok(maskdir_q[`BKC_COMP_A_DIR_CHECK_ENABLE], maskdir_q[`BKC_RWA],
    i_cpu_read);
  // B direction bits are ignored in full mode
  wire dir_b = full | dir_ok(maskdir_q[`BKC_COMP_B_DIR_CHECK_ENABLE], maskdir_q[`BKC_RWB],
    i_cpu_read);

  // Full mode needs address on A and data on B together
  wire hit_a = i_bus_valid & addr_a_ok & dir_a & (~full | data_b_ok);
  wire hit_b = i_bus_valid & ~full & addr_b_ok & dir_b;

  // Registered so the outputs come from flip-flops; one cycle late
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_match_a <= 1'b0;
      o_match_b <= 1'b0;
    end else begin
      o_match_a <= hit_a;
      o_match_b <= hit_b;
    end
  end

  // Register writes; selectors reset to 00 as software expects
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      maskdir_q <= `BKC_RST_BYTE;
      cax_q <= `BKC_RST_BYTE;
      cah_q <= `BKC_RST_BYTE;
      cal_q <= `BKC_RST_BYTE;
      cbx_q <= `BKC_RST_BYTE;
      cbh_q <= `BKC_RST_BYTE;
      cbl_q <= `BKC_RST_BYTE;
      ctrl_q <= `BKC_RST_CTRL;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `BKC_OFF_MASKDIR: begin
          maskdir_q <= i_reg_wdata;
        end
        `BKC_OFF_CAX: begin
          cax_q <= i_reg_wdata;
        end
        `BKC_OFF_CAH: begin
          cah_q <= i_reg_wdata;
        end
        `BKC_OFF_CAL: begin
          cal_q <= i_reg_wdata;
        end
        `BKC_OFF_CBX: begin
          cbx_q <= i_reg_wdata;
        end
        `BKC_OFF_CBH: begin
          cbh_q <= i_reg_wdata;
        end
        `BKC_OFF_CBL: begin
          cbl_q <= i_reg_wdata;
        end
        `BKC_OFF_CTRL: begin
          ctrl_q <= i_reg_wdata[2:0];
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_d = `BKC_RST_BYTE;
    case (i_reg_addr)
      `BKC_OFF_MASKDIR: rdata_d = maskdir_q;
      `BKC_OFF_CAX: rdata_d = cax_q;
      `BKC_OFF_CAH: rdata_d = cah_q;
      `BKC_OFF_CAL: rdata_d = cal_q;
      `BKC_OFF_CBX: rdata_d = cbx_q;
      `BKC_OFF_CBH: rdata_d = cbh_q;
      `BKC_OFF_CBL: rdata_d = cbl_q;
      `BKC_OFF_CTRL: rdata_d = {5'h00, ctrl_q};
      `BKC_OFF_STAT: rdata_d = {4'h0, o_match_b, o_match_a, trace, legacy};
      default: rdata_d = `BKC_RST_BYTE;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= `BKC_RST_BYTE;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= `BKC_RST_BYTE;
    end
  end
endmodule

// >>> bench/bkc_props.sv
/*
 Checker for the breakpoint compare block, bound to its top module.
 Assumes registers change only through the write strobe.
*/
`timescale 1ns/1ps
module bkc_props (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_bus_valid,
  input wire [15:0] i_cpu_addr,
  input wire i_cpu_read,
  input wire i_flash_access,
  input wire o_match_a,
  input wire o_match_b
);
  // Shadows kept here so no expectation is read back from the design
  logic [2:0] c_q;
  logic [7:0] m_q;
  logic [7:0] ah_q;
  logic [7:0] al_q;
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      c_q <= 3'h0;
      m_q <= 8'h00;
      ah_q <= 8'h00;
      al_q <= 8'h00;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        8'h20: c_q <= i_reg_wdata[2:0];
        8'h29: m_q <= i_reg_wdata;
        8'h2b: ah_q <= i_reg_wdata;
        8'h2c: al_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end
  wire plain = i_bus_valid && c_q == 3'h0;
  wire hit = i_cpu_addr == {ah_q, al_q};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_idle; !i_bus_valid |=> !o_match_a && !o_match_b; endproperty
  a_idle: assert property (p_idle)
    else $error("match without access");
  property p_hit_a; plain && !m_q[6] && !m_q[3] && hit |=> o_match_a;
  endproperty
  a_hit_a: assert property (p_hit_a)
    else $error("full compare missed");
  property p_miss_a; plain && !m_q[6] && !hit |=> !o_match_a; endproperty
  a_miss_a: assert property (p_miss_a)
    else $error("full compare false hit");
  property p_range_a;
    plain && m_q[7:6] == 2'h1 && !m_q[3] && i_cpu_addr[15:8] == ah_q
      |=> o_match_a;
  endproperty
  a_range_a: assert property (p_range_a)
    else $error("range compare missed");
  property p_dir_a; i_bus_valid && m_q[3] && i_cpu_read != m_q[2]
    |=> !o_match_a; endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("A direction ignored");
  property p_dir_b; i_bus_valid && !c_q[2] && m_q[1] &&
    i_cpu_read != m_q[0] |=> !o_match_b; endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("B direction ignored");
  property p_full_b; c_q[2] |=> !o_match_b; endproperty
  a_full_b: assert property (p_full_b)
    else $error("B address match in full mode");
  property p_legacy; i_bus_valid && c_q == 3'h1 && !i_flash_access &&
    !m_q[6] && !hit |=> !o_match_a; endproperty
  a_legacy: assert property (p_legacy)
    else $error("unpaged legacy false hit");
  c_a: cover property (i_bus_valid ##1 o_match_a);
  c_b: cover property (o_match_b);
  c_full: cover property (c_q[2] ##1 o_match_a);
endmodule

// >>> bench/bkc_core_model.sv
/*
 Core bus model: one access per call, then a scrambled idle bus.
 Assumes the caller shares the bus clock.
*/
`timescale 1ns/1ps
module bkc_core_model (
  input wire i_clk,
  output logic o_valid = 1'h0,
  output logic [15:0] o_addr = 16'h0000,
  output logic [21:14] o_ext = 8'h00,
  output logic [15:0] o_data = 16'h0000,
  output logic o_read = 1'h0,
  output logic o_page = 1'h0,
  output logic o_flash = 1'h0
);
  task access(input [15:0] a, input [7:0] x, input [15:0] d,
              input [2:0] f);
    @(posedge i_clk);
    o_valid <= 1'h1;
    o_addr <= a;
    o_ext <= x;
    o_data <= d;
    {o_read, o_page, o_flash} <= f;
    @(posedge i_clk);
    // Idle bus is inverted so a stale value can never match
    o_valid <= 1'h0;
    o_addr <= ~a;
    o_ext <= ~x;
    o_data <= ~d;
  endtask
endmodule

// >>> bench/bkc_breakpoint_compare_tb.sv
/*
 Bench for the breakpoint compare block: row table, then hand tests.
 Assumes the core model and checker files compile before it.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module bkc_breakpoint_compare_tb;
  // Flags are read, page, flash, expected A, expected B
  typedef struct packed {
    logic [2:0] c;
    logic [7:0] m;
    logic [15:0] a;
    logic [7:0] x;
    logic [15:0] d;
    logic [4:0] f;
  } bkc_row_t;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'h0;
  logic i_reg_rd = 1'h0;
  logic i_secure = 1'h0;
  wire i_bus_valid, i_cpu_read, i_page_sel, i_flash_access;
  wire [15:0] i_cpu_addr, i_cpu_data;
  wire [21:14] i_ext_addr;
  wire [7:0] o_reg_rdata;
  wire o_match_a, o_match_b;
  int checks = 0;
  int bad_count = 0;
  bkc_row_t rows [18] = '{
    '{3'h0,8'h00,16'h1234,8'h00,16'h0000,5'h12},
    '{3'h0,8'h80,16'h1235,8'h00,16'h0000,5'h10},
    '{3'h0,8'h40,16'h12ff,8'h00,16'h0000,5'h12},
    '{3'h0,8'h10,16'h56aa,8'h00,16'h0000,5'h11},
    '{3'h0,8'h20,16'h5679,8'h00,16'h0000,5'h10},
    '{3'h1,8'h00,16'hd234,8'hc5,16'h0000,5'h16},
    '{3'h1,8'h00,16'hd234,8'hc6,16'h0000,5'h14},
    '{3'h1,8'h00,16'hd234,8'hc5,16'h0000,5'h10},
    '{3'h1,8'hc0,16'h0000,8'hc5,16'h0000,5'h16},
    '{3'h4,8'h00,16'h1234,8'h00,16'h5678,5'h12},
    '{3'h4,8'h20,16'h1234,8'h00,16'h0078,5'h12},
    '{3'h4,8'h30,16'h1234,8'h00,16'h0000,5'h12},
    '{3'h4,8'h10,16'h1234,8'h00,16'h5700,5'h10},
    '{3'h0,8'h08,16'h1234,8'h00,16'h0000,5'h10},
    '{3'h0,8'h0c,16'h1234,8'h00,16'h0000,5'h12},
    '{3'h0,8'h02,16'h5678,8'h00,16'h0000,5'h10},
    '{3'h0,8'h03,16'h5678,8'h00,16'h0000,5'h11},
    '{3'h4,8'h02,16'h1234,8'h00,16'h5678,5'h12}};
  always #5 i_clk = ~i_clk;
  bkc_breakpoint_compare dut (.*);
  bkc_core_model core (.i_clk(i_clk), .o_valid(i_bus_valid),
    .o_addr(i_cpu_addr), .o_ext(i_ext_addr), .o_data(i_cpu_data),
    .o_read(i_cpu_read), .o_page(i_page_sel), .o_flash(i_flash_access));
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] k);
    @(posedge i_clk);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'h0;
    #1;
    `CHK("rdata", e, o_reg_rdata & k)
  endtask
  task run(input bkc_row_t r, input int n);
    wr(8'h20, {5'h00, r.c});
    wr(8'h29, r.m);
    core.access(r.a, r.x, r.d, r.f[4:2]);
    #1;
    `CHK("match_a", r.f[1], o_match_a)
    `CHK("match_b", r.f[0], o_match_b)
    $display("test %0d done", n);
  endtask
  task end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rd(8'h2a, 8'h00, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    wr(8'h2a, 8'h05);
    wr(8'h2b, 8'h12);
    wr(8'h2c, 8'h34);
    wr(8'h2d, 8'h07);
    wr(8'h2e, 8'h56);
    wr(8'h2f, 8'h78);
    rd(8'h2a, 8'h05, 8'hff);
    foreach (rows[i]) run(rows[i], i);
    wr(8'h2a, 8'h45);
    run('{3'h2,8'h00,16'hd234,8'h14,16'h0000,5'h1a}, 90);
    run('{3'h2,8'h00,16'hd234,8'h15,16'h0000,5'h18}, 91);
    wr(8'h2a, 8'hc5);
    run('{3'h2,8'h00,16'hd234,8'h14,16'h0000,5'h1a}, 92);
    wr(8'h2a, 8'h85);
    run('{3'h2,8'h00,16'hd234,8'h14,16'h0000,5'h18}, 93);
    wr(8'h20, 8'h03);
    rd(8'h30, 8'h01, 8'h03);
    @(posedge i_clk) i_secure <= 1'h1;
    wr(8'h20, 8'h02);
    rd(8'h30, 8'h00, 8'h03);
    @(posedge i_clk) i_secure <= 1'h0;
    wr(8'h20, 8'h02);
    rd(8'h30, 8'h02, 8'h03);
    $display("mode tests done");
    end_sim;
  end
  initial begin
    #50000;
    bad_count++;
    end_sim;
  end
endmodule
bind bkc_breakpoint_compare bkc_props u_props (.*);
